// file: bench/sadc_ctrl_props.sv
// Assertions on the converter control ports
`timescale 1ns/1ps
module sadc_chk #(parameter int CONV_CYCLES = 200) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        select_n,
    input wire logic        read_convert,
    input wire logic        half_select,
    input wire logic        busy_n,
    input wire logic [15:0] result_bus,
    input wire logic [15:0] result_bus_oe_n
);
    logic [15:0] cnt;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            cnt <= 16'h0000;
        else
            cnt <= busy_n ? 16'h0000 : cnt + 16'h0001;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence rd_on; (!select_n && read_convert) [*5]; endsequence
    sequence rd_off; (select_n || !read_convert) [*5]; endsequence
    out_on_a: assert property (rd_on |-> result_bus_oe_n == 16'h0000) else $error("not driven");
    out_float_a: assert property (rd_off |-> result_bus_oe_n == 16'hFFFF) else $error("not floating");
    rc_start_a: assert property (busy_n && !select_n && $fell(read_convert) |-> ##[2:5] !busy_n)
        else $error("no start");
    sel_start_a: assert property (busy_n && !read_convert && $fell(select_n) |-> ##[2:5] !busy_n)
        else $error("no start");
    byte_sel_a: assert property (!half_select [*4] |-> result_bus[7:0] == result_bus[15:8]) else $error("byte");
    busy_min_a: assert property ($rose(busy_n) |-> cnt >= CONV_CYCLES - 1) else $error("busy short");
    busy_max_a: assert property ($rose(busy_n) |-> cnt <= CONV_CYCLES + 2) else $error("busy long");
    result_hold_a: assert property (!$rose(busy_n) |-> $stable(result_bus[15:8])) else $error("changed");
endmodule
bind sadc_ctrl sadc_chk #(.CONV_CYCLES(CONV_CYCLES)) i_sadc_chk (.*);

// file: bench/sadc_ctrl_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sadc_ctrl_tb;
    logic mclk = 0, rst = 1, select_n = 1, read_convert = 1, half_select = 1;
    logic busy_n, sample_valid, sample_ready;
    logic [15:0] result_bus, result_bus_oe_n, sample_data, prev;
    logic [15:0] tbl [4] = '{16'h8000, 16'h7FFF, 16'hFFFF, 16'h0001};
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    always #20 mclk = ~mclk;
    sadc_ctrl #(.CONV_CYCLES(20)) i_sadc_ctrl (.*);
    sadc_src i_sadc_src (.*);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(negedge mclk);
    endtask
    task automatic wait_busy(input logic v);
        for (int t = 0; t < 100 && busy_n !== v; t++) @(negedge mclk);
        chk({15'h0000, busy_n}, {15'h0000, v});
    endtask
    task automatic convert(input logic by_select, input int n);
        if (by_select)
            read_convert = 0;
        else
            select_n = 0;
        tick(1);
        select_n = 0;
        read_convert = 0;
        wait_busy(0);
        read_convert = 1;
        tick(5);
        chk(result_bus, prev);
        read_convert = 0;
        tick(2);
        read_convert = 1;
        wait_busy(1);
        prev = tbl[n % 4];
        tick(5);
        chk(result_bus, prev);
        chk(result_bus_oe_n, 16'h0000);
        half_select = 0;
        tick(4);
        chk(result_bus, {prev[15:8], prev[15:8]});
        half_select = 1;
        select_n = 1;
        tick(8);
        chk(result_bus_oe_n, 16'hFFFF);
        chk({15'h0000, busy_n}, 16'h0001);
        chk({15'h0000, sample_ready}, 16'h0000);
    endtask
    task automatic print_verdict;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            print_verdict;
        end
    end
    initial begin
        tick(6);
        rst = 0;
        tick(3);
        prev = 16'h0000;
        for (int i = 0; i < 6; i++) convert(i[0], i);
        print_verdict;
    end
endmodule

// file: bench/sadc_src.sv
// Sample source that keeps the FIFO supplied
`timescale 1ns/1ps
module sadc_src (
    input wire logic   mclk,
    input wire logic   rst,
    input wire logic   sample_ready,
    output logic [15:0] sample_data,
    output logic        sample_valid
);
    logic [1:0] k;
    assign sample_valid = !rst;
    always_comb begin
        case (k)
            2'h0: sample_data = 16'h8000;
            2'h1: sample_data = 16'h7FFF;
            2'h2: sample_data = 16'hFFFF;
            default: sample_data = 16'h0001;
        endcase
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            k <= 2'h0;
        else if (sample_ready)
            k <= k + 2'h1;
    end
endmodule

// file: core/sadc_ctrl.sv
// Converter control, result register and tri-state parallel readout
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_ctrl
    import sadc_pkg::*;
#(
    parameter int CONV_CYCLES = `SADC_CONV_CYCLES,
    parameter int FIFO_DEPTH  = `SADC_FIFO_DEPTH
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        select_n,
    input  wire logic        read_convert,
    input  wire logic        half_select,
    output logic             busy_n,
    output logic [15:0]      result_bus,
    output logic [15:0]      result_bus_oe_n,
    input  wire logic [15:0] sample_data,
    input  wire logic        sample_valid,
    output logic             sample_ready
);
    initial begin
        if (CONV_CYCLES < 2 || CONV_CYCLES > 65535) $error("CONV_CYCLES out of range");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  sel_sync;
        logic [1:0]  rc_sync;
        logic [1:0]  half_sync;
        logic        sel_d;
        logic        rc_d;
        sadc_state_t state;
        logic [15:0] count;
        logic [15:0] result;
        logic        busy_n;
        logic        oe;
        logic [15:0] bus;
    } sadc_ctrl_st_t;
    sadc_ctrl_st_t st;
    sadc_ctrl_st_t next_st;

    logic [15:0] fifo_data;
    logic        fifo_valid;
    logic        fifo_take;
    logic        sel;
    logic        rc;
    logic        half;
    logic        cmd_low;
    logic        cmd_fall;

    // ----------------------------------------------------------------
    // Sample buffer from the quantiser
    // ----------------------------------------------------------------
    sadc_fifo #(
        .WIDTH (`SADC_RESULT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_data   (sample_data),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_take)
    );

    assign sel      = st.sel_sync[1];
    assign rc       = st.rc_sync[1];
    assign half     = st.half_sync[1];
    // Select and convert are OR'd: the command is active when both low
    assign cmd_low  = !sel && !rc;
    assign cmd_fall = cmd_low && !(!st.sel_d && !st.rc_d);
    // Conversion ends only once a quantised sample is available
    assign fifo_take = (st.state == SADC_CONV) && (st.count == '0) && fifo_valid;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.sel_sync  = {st.sel_sync[0], select_n};
        next_st.rc_sync   = {st.rc_sync[0], read_convert};
        next_st.half_sync = {st.half_sync[0], half_select};
        next_st.sel_d     = sel;
        next_st.rc_d      = rc;
        case (st.state)
            SADC_IDLE: begin
                if (cmd_fall) begin
                    next_st.state  = SADC_CONV;
                    next_st.count  = 16'(CONV_CYCLES - 1);
                    next_st.busy_n = 1'b0;
                end
            end
            SADC_CONV: begin
                // New commands have no effect here
                if (st.count != '0) begin
                    next_st.count = st.count - 16'h0001;
                end else if (fifo_valid) begin
                    next_st.result = fifo_data;
                    next_st.busy_n = 1'b1;
                    next_st.state  = SADC_IDLE;
                end
            end
            default: begin
                next_st.state  = SADC_IDLE;
                next_st.busy_n = 1'b1;
            end
        endcase
        // Outputs driven only with select low and convert high
        next_st.oe = !sel && rc;
        // Half select low shows bits 15..8 on the low lanes, high shows 7..0
        if (half) begin
            next_st.bus = {8'h00, next_st.result[7:0]};
        end else begin
            next_st.bus = {8'h00, next_st.result[15:8]};
        end
        next_st.bus[15:8] = next_st.result[15:8];
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st          <= '0;
            st.sel_sync <= 2'h3;
            st.rc_sync  <= 2'h3;
            st.half_sync <= 2'h0;
            st.sel_d    <= 1'b1;
            st.rc_d     <= 1'b1;
            st.state    <= SADC_IDLE;
            st.result   <= `SADC_RESET_RESULT;
            st.busy_n   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign busy_n          = st.busy_n;
    assign result_bus      = st.bus;
    assign result_bus_oe_n = {16{!st.oe}};
endmodule

// file: core/sadc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sadc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two >= 2");
    end
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } sadc_fifo_st_t;
    sadc_fifo_st_t st;
    sadc_fifo_st_t next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data  = mem[st.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) next_st.wp = st.wp + 1'b1;
        if (pop) next_st.rp = st.rp + 1'b1;
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[st.wp] <= in_data;
        end
    end
endmodule

// file: core/sadc_params.svh
// Constants for the parallel converter control block
// Overview of operation
// - Select low, not busy: convert falling starts conversion
// - Convert low: select falling starts conversion
// - Select low, convert rising enables outputs
// - Outputs float when select high or convert low
// - Half select low upper byte, high lower
// - Busy low from start until result updated
// - Result bit 15 is MSB, bit 0 LSB
// - Result coded as 16-bit two's complement
// - Requests ignored while busy is low
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
`define SADC_RESULT_W     16
`define SADC_HALF_W       8
`define SADC_CONV_TIME_NS 8000
`define SADC_CLK_NS       40
`define SADC_CONV_CYCLES  ((`SADC_CONV_TIME_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_FIFO_DEPTH   8
`define SADC_RESET_RESULT 16'h0000
`endif

// file: core/sadc_pkg.sv
// Types for the parallel converter control block
package sadc_pkg;
    typedef enum logic [1:0] {
        SADC_IDLE = 2'b01,
        SADC_CONV = 2'b10
    } sadc_state_t;
endpackage
